/* logic/flash_write_defines.svh */
// constants of the buffer-write and page-program command path
// included by the package and the design modules by its bare name
`ifndef FLASH_WRITE_DEFINES_SVH
`define FLASH_WRITE_DEFINES_SVH

// ****************************************************************
// opcodes
// ****************************************************************
`define OP_LOAD_BUF1 8'h84
`define OP_LOAD_BUF2 8'h87
`define OP_ERPROG_BUF1 8'h83
`define OP_ERPROG_BUF2 8'h86
`define OP_PROG_BUF1 8'h88
`define OP_PROG_BUF2 8'h89
`define OP_LOADPROG_BUF1 8'h82
`define OP_LOADPROG_BUF2 8'h85

// ****************************************************************
// address layout and buffer size
// ****************************************************************
`define ADDR_LAST_BYTE 2'h2
`define BUF_LAST_WIDE 9'h107
`define BUF_LAST_NARROW 9'h0FF
`define WIDE_PAGE_LSB 9
`define NARROW_PAGE_LSB 8

// ****************************************************************
// timing
// ****************************************************************
`define CLK_PERIOD_NS 32'h0000_000A
`define ERASE_PROGRAM_TIME_MAX_NS 32'h0000_9C40
`define PROGRAM_TIME_MAX_NS 32'h0000_4E20

`endif

/* logic/flash_write_pkg.sv */
// types shared by the command path and the self-timed engine
// assumes flash_write_defines.svh is on the include path
`include "flash_write_defines.svh"

package flash_write_pkg;

    typedef enum logic [2:0] {
        KIND_NONE,
        KIND_LOAD,
        KIND_ERPROG,
        KIND_PROG,
        KIND_LOADPROG
    } cmd_kind_t;

    typedef enum logic [1:0] {
        CMD_OPCODE = 2'b00,
        CMD_ADDR = 2'b01,
        CMD_DATA = 2'b11,
        CMD_IGNORE = 2'b10
    } cmd_state_t;

    typedef enum logic [1:0] {
        ENG_IDLE = 2'b00,
        ENG_ERASE = 2'b01,
        ENG_PROG = 2'b11,
        ENG_PAD = 2'b10
    } eng_state_t;

    typedef struct packed {
        logic erase_first;
        logic buf_sel;
        logic [10:0] page;
    } op_req_t;

    typedef struct packed {
        logic valid;
        logic [10:0] page;
        logic [8:0] offset;
        logic [7:0] data;
    } array_wr_t;

    function automatic logic [8:0] buf_last(input logic narrow);
        return narrow ? `BUF_LAST_NARROW : `BUF_LAST_WIDE;
    endfunction

endpackage

/* logic/flash_op_engine.sv */
// self-timed erase and program sequencer for one buffer-to-page job
// assumes the array reports a failed location on array_fail, same clock
`timescale 1ns/1ns
`default_nettype none
`include "flash_write_defines.svh"

module flash_op_engine
    import flash_write_pkg::*;
#(
    parameter int CNT_W = 16,
    parameter int ERASE_CYC = 2000,
    parameter int PROG_CYC = 2000
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic start,
    input wire op_req_t req,
    input wire logic narrow,
    input wire logic array_fail,
    output logic busy,
    output logic error,
    output logic array_erase,
    output logic step,
    output logic [8:0] idx,
    output op_req_t cur
);

    eng_state_t state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [8:0] idx_q, idx_d;
    logic err_q, err_d;
    logic ers_q, ers_d;
    op_req_t req_q, req_d;

    // ****************************************************************
    // sequencer
    // ****************************************************************
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q + 1'b1;
        idx_d = idx_q;
        err_d = err_q;
        ers_d = 1'b0;
        req_d = req_q;
        case (state_q)
            ENG_IDLE: begin
                cnt_d = '0;
                if (start) begin
                    req_d = req;
                    err_d = 1'b0;
                    idx_d = '0;
                    if (req.erase_first) begin
                        state_d = ENG_ERASE; // [RQ10]
                        ers_d = 1'b1;
                    end else begin
                        state_d = ENG_PROG; // [RQ13]
                    end
                end
            end
            ENG_ERASE: begin
                if (cnt_q == CNT_W'(ERASE_CYC - 1)) begin
                    state_d = ENG_PROG;
                    cnt_d = '0;
                end
            end
            ENG_PROG: begin
                if (idx_q == buf_last(narrow)) begin
                    state_d = ENG_PAD;
                end else begin
                    idx_d = idx_q + 9'h001;
                end
            end
            ENG_PAD: begin
                // pad so the program phase always takes the full budget
                if (cnt_q >= CNT_W'(PROG_CYC - 1)) begin
                    state_d = ENG_IDLE; // [RQ15] [RQ19]
                end
            end
            default: state_d = ENG_IDLE;
        endcase
        if (state_q != ENG_IDLE && array_fail) begin
            err_d = 1'b1; // [RQ12]
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= ENG_IDLE;
            cnt_q <= '0;
            idx_q <= '0;
            err_q <= 1'b0;
            ers_q <= 1'b0;
            req_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            idx_q <= idx_d;
            err_q <= err_d;
            ers_q <= ers_d;
            req_q <= req_d;
        end
    end

    assign busy = (state_q != ENG_IDLE); // [RQ11]
    assign error = err_q;
    assign array_erase = ers_q;
    assign step = (state_q == ENG_PROG);
    assign idx = idx_q;
    assign cur = req_q;

    // ****************************************************************
    // checks
    // ****************************************************************
    logic [CNT_W:0] busy_cnt_q;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            busy_cnt_q <= '0;
        end else begin
            busy_cnt_q <= busy ? busy_cnt_q + 1'b1 : '0;
        end
    end

    sequence s_start_erase;
        start && !busy && req.erase_first;
    endsequence

    a_busy_on_start: assert property (@(posedge clk) disable iff (!rst_b) // [RQ11]
        start && !busy |=> busy)
        else $error("engine not busy after start");
    a_erase_first: assert property (@(posedge clk) disable iff (!rst_b) // [RQ10]
        s_start_erase |=> array_erase && state_q == ENG_ERASE)
        else $error("erase did not open the sequence");
    a_no_erase_prog: assert property (@(posedge clk) disable iff (!rst_b) // [RQ13]
        array_erase |-> req_q.erase_first && $past(state_q) == ENG_IDLE)
        else $error("erase issued for a program-only job");
    a_time_bound: assert property (@(posedge clk) disable iff (!rst_b) // [RQ15]
        busy |-> busy_cnt_q < (CNT_W+1)'(req_q.erase_first ?
            ERASE_CYC + PROG_CYC : PROG_CYC))
        else $error("operation exceeded its time limit");
    a_error_set: assert property (@(posedge clk) disable iff (!rst_b) // [RQ12]
        busy && array_fail |=> error)
        else $error("failed location did not raise error");
    a_busy_release: assert property (@(posedge clk) disable iff (!rst_b) // [RQ19]
        $fell(busy) |-> $past(state_q) == ENG_PAD)
        else $error("busy dropped before sequence end");

endmodule // flash_op_engine

`default_nettype wire

/* logic/flash_write_path.sv */
// serial command path for buffer loads and buffer-to-page programming
// assumes SPI mode 0 on sck/cs_b/si and an array behind array_* ports
//
// Behaviour
// (RQ1) opcode 84h loads buffer 1, 87h buffer 2, then three address bytes
// (RQ2) wide pages: 15 ignored bits then a 9-bit start offset
// (RQ3) narrow pages: 16 ignored bits then an 8-bit start offset
// (RQ4) data bytes fill successive buffer bytes, wrapping to offset zero
// (RQ5) loading continues until chip select rises
// (RQ6) opcodes 83h/86h program buffer 1/2 into a page with erase
// (RQ7) wide pages: 4 ignored bits, 11-bit page, 9 ignored bits
// (RQ8) narrow erase-program: 5 ignored bits, page from address bits 18..8
// (RQ9) narrow program-only: page from bits 18..8, low byte ignored
// (RQ10) chip select rise erases page then programs it, within time limit
// (RQ11) busy shows while any erase or program runs
// (RQ12) a location failing erase or program sets the error flag
// (RQ13) opcodes 88h/89h program buffer 1/2 without erase
// (RQ14) host erases the target page before a program-only command
// (RQ15) program-only job finishes within the shorter program limit
// (RQ16) opcodes 82h/85h load then erase-program; wide: page and offset
// (RQ17) narrow load-then-program ends its address with an 8-bit offset
// (RQ18) combined command loads with wrap, then erases and programs
// (RQ19) busy clears when the sequence finishes
`timescale 1ns/1ns
`default_nettype none
`include "flash_write_defines.svh"

module flash_write_path
    import flash_write_pkg::*;
#(
    parameter int BUF_DEPTH = 264,
    parameter int PROG_CYC = `PROGRAM_TIME_MAX_NS / `CLK_PERIOD_NS,
    parameter int EP_CYC = `ERASE_PROGRAM_TIME_MAX_NS / `CLK_PERIOD_NS
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic sck,
    input wire logic cs_b,
    input wire logic si,
    input wire logic page_256,
    input wire logic array_fail,
    output logic busy,
    output logic erase_program_error_flag,
    output logic array_erase,
    output logic [10:0] array_page,
    output array_wr_t array_wr
);

    // ****************************************************************
    // address decode
    // ****************************************************************
    function automatic logic [8:0] start_offset(input logic [23:0] a,
                                                input logic narrow);
        return narrow ? {1'b0, a[7:0]} : a[8:0]; // [RQ2] [RQ3] [RQ17]
    endfunction

    function automatic logic [10:0] page_sel(input logic [23:0] a,
                                             input logic narrow);
        // [RQ7] [RQ8] [RQ9] [RQ16]
        return narrow ? a[`NARROW_PAGE_LSB +: 11] : a[`WIDE_PAGE_LSB +: 11];
    endfunction

    // ****************************************************************
    // link side, clocked by sck
    // ****************************************************************
    // the bit counter is held clear while cs_b is high, so a frame
    // always starts on a byte boundary and a partial byte is dropped
    logic [2:0] bit_q, bit_d;
    logic [6:0] sh_q, sh_d;
    logic [7:0] lbyte_q, lbyte_d;
    logic ltog_q, ltog_d;

    always_comb begin
        bit_d = bit_q + 3'h1;
        sh_d = {sh_q[5:0], si};
        lbyte_d = lbyte_q;
        ltog_d = ltog_q;
        if (bit_q == 3'h7) begin
            lbyte_d = {sh_q, si};
            ltog_d = ~ltog_q;
        end
    end

    always_ff @(posedge sck or posedge cs_b) begin
        if (cs_b) begin
            bit_q <= '0;
            sh_q <= '0;
        end else begin
            bit_q <= bit_d;
            sh_q <= sh_d;
        end
    end

    // the toggle is not cleared by cs_b: a clear would look like a byte
    always_ff @(posedge sck or negedge rst_b) begin
        if (!rst_b) begin
            lbyte_q <= '0;
            ltog_q <= 1'b0;
        end else begin
            lbyte_q <= lbyte_d;
            ltog_q <= ltog_d;
        end
    end

    // ****************************************************************
    // crossings into clk
    // ****************************************************************
    logic tog_s1, tog_s2, tog_s3;
    logic cs_s1, cs_s2, cs_s3;
    logic nar_s1, nar_s2;
    logic byte_ev, cs_rise;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tog_s1 <= 1'b0;
            tog_s2 <= 1'b0;
            tog_s3 <= 1'b0;
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            cs_s3 <= 1'b1;
            nar_s1 <= 1'b0;
            nar_s2 <= 1'b0;
        end else begin
            tog_s1 <= ltog_q;
            tog_s2 <= tog_s1;
            tog_s3 <= tog_s2;
            cs_s1 <= cs_b;
            cs_s2 <= cs_s1;
            cs_s3 <= cs_s2;
            nar_s1 <= page_256;
            nar_s2 <= nar_s1;
        end
    end

    // lbyte_q stays put for eight sck periods, long after the toggle lands
    assign byte_ev = tog_s2 ^ tog_s3;
    assign cs_rise = cs_s2 & ~cs_s3;

    // ****************************************************************
    // command decoder
    // ****************************************************************
    cmd_state_t st_q, st_d;
    cmd_kind_t kind_q, kind_d;
    logic bsel_q, bsel_d;
    logic [23:0] addr_q, addr_d;
    logic [1:0] acnt_q, acnt_d;
    logic [8:0] off_q, off_d;
    logic start_q, start_d;
    op_req_t req_q, req_d;
    logic buf_we;
    logic loads;
    logic eng_busy;
    logic [23:0] addr_n;

    assign loads = (kind_q == KIND_LOAD) || (kind_q == KIND_LOADPROG);
    assign buf_we = byte_ev && (st_q == CMD_DATA) && loads && !cs_rise;
    assign addr_n = {addr_q[15:0], lbyte_q};

    always_comb begin
        st_d = st_q;
        kind_d = kind_q;
        bsel_d = bsel_q;
        addr_d = addr_q;
        acnt_d = acnt_q;
        off_d = off_q;
        start_d = 1'b0;
        req_d = req_q;
        if (cs_rise) begin
            st_d = CMD_OPCODE; // [RQ5]
            if (st_q == CMD_DATA && kind_q != KIND_LOAD && !eng_busy) begin
                start_d = 1'b1; // [RQ10] [RQ13] [RQ18]
            end
        end else if (byte_ev) begin
            case (st_q)
                CMD_OPCODE: begin
                    st_d = CMD_ADDR;
                    acnt_d = '0;
                    case (lbyte_q)
                        `OP_LOAD_BUF1, `OP_LOAD_BUF2:
                            kind_d = KIND_LOAD; // [RQ1]
                        `OP_ERPROG_BUF1, `OP_ERPROG_BUF2:
                            kind_d = KIND_ERPROG; // [RQ6]
                        `OP_PROG_BUF1, `OP_PROG_BUF2:
                            kind_d = KIND_PROG; // [RQ13]
                        `OP_LOADPROG_BUF1, `OP_LOADPROG_BUF2:
                            kind_d = KIND_LOADPROG; // [RQ16]
                        default: begin
                            kind_d = KIND_NONE;
                            st_d = CMD_IGNORE;
                        end
                    endcase
                    bsel_d = (lbyte_q == `OP_LOAD_BUF2) ||
                             (lbyte_q == `OP_ERPROG_BUF2) ||
                             (lbyte_q == `OP_PROG_BUF2) ||
                             (lbyte_q == `OP_LOADPROG_BUF2);
                end
                CMD_ADDR: begin
                    addr_d = addr_n;
                    acnt_d = acnt_q + 2'h1;
                    if (acnt_q == `ADDR_LAST_BYTE) begin
                        st_d = CMD_DATA;
                        off_d = start_offset(addr_n, nar_s2);
                        req_d.erase_first = (kind_q != KIND_PROG);
                        req_d.buf_sel = bsel_q;
                        req_d.page = page_sel(addr_n, nar_s2);
                    end
                end
                CMD_DATA: begin
                    if (loads) begin
                        // [RQ4] [RQ18]
                        off_d = (off_q == buf_last(nar_s2)) ?
                                9'h000 : off_q + 9'h001;
                    end
                end
                default: st_d = st_q;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= CMD_OPCODE;
            kind_q <= KIND_NONE;
            bsel_q <= 1'b0;
            addr_q <= '0;
            acnt_q <= '0;
            off_q <= '0;
            start_q <= 1'b0;
            req_q <= '0;
        end else begin
            st_q <= st_d;
            kind_q <= kind_d;
            bsel_q <= bsel_d;
            addr_q <= addr_d;
            acnt_q <= acnt_d;
            off_q <= off_d;
            start_q <= start_d;
            req_q <= req_d;
        end
    end

    // ****************************************************************
    // page buffers and program data path
    // ****************************************************************
    logic [7:0] mem1 [0:BUF_DEPTH-1];
    logic [7:0] mem2 [0:BUF_DEPTH-1];
    logic [7:0] rd_data_q;
    logic step;
    logic [8:0] idx;
    op_req_t cur;
    logic wr_valid_q;
    logic [8:0] wr_off_q;

    always_ff @(posedge clk) begin
        if (buf_we && !bsel_q) begin
            mem1[off_q] <= lbyte_q; // [RQ4]
        end
        if (buf_we && bsel_q) begin
            mem2[off_q] <= lbyte_q;
        end
        rd_data_q <= cur.buf_sel ? mem2[idx] : mem1[idx];
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_valid_q <= 1'b0;
            wr_off_q <= '0;
        end else begin
            wr_valid_q <= step;
            wr_off_q <= idx;
        end
    end

    assign array_wr = '{valid: wr_valid_q, page: cur.page,
                        offset: wr_off_q, data: rd_data_q};
    assign array_page = cur.page;
    assign busy = eng_busy;

    flash_op_engine #(
        .CNT_W(16),
        .ERASE_CYC(EP_CYC - PROG_CYC),
        .PROG_CYC(PROG_CYC)
    ) u_engine (
        .clk(clk),
        .rst_b(rst_b),
        .start(start_q),
        .req(req_q),
        .narrow(nar_s2),
        .array_fail(array_fail),
        .busy(eng_busy),
        .error(erase_program_error_flag),
        .array_erase(array_erase),
        .step(step),
        .idx(idx),
        .cur(cur)
    );

    // ****************************************************************
    // checks
    // ****************************************************************
    sequence s_load_opcode;
        byte_ev && !cs_rise && st_q == CMD_OPCODE &&
            (lbyte_q == `OP_LOAD_BUF1 || lbyte_q == `OP_LOAD_BUF2);
    endsequence

    a_load_opcode: assert property (@(posedge clk) disable iff (!rst_b) // [RQ1]
        s_load_opcode |=> kind_q == KIND_LOAD && st_q == CMD_ADDR &&
            bsel_q == ($past(lbyte_q) == `OP_LOAD_BUF2))
        else $error("load opcode decoded wrongly");
    a_load_wrap: assert property (@(posedge clk) disable iff (!rst_b) // [RQ4]
        buf_we && off_q == buf_last(nar_s2) |=> off_q == 9'h000)
        else $error("buffer offset did not wrap");
    a_cs_ends_load: assert property (@(posedge clk) disable iff (!rst_b) // [RQ5]
        cs_rise |=> st_q == CMD_OPCODE && !buf_we)
        else $error("load continued past chip select rise");
    a_start_cause: assert property (@(posedge clk) disable iff (!rst_b) // [RQ10]
        start_q |-> $past(cs_rise) && $past(st_q) == CMD_DATA &&
            $past(kind_q) != KIND_LOAD)
        else $error("engine started without a finished command");

endmodule // flash_write_path

`default_nettype wire

/* verif/spi_host_model.sv */
// host-side serial master that frames commands for the write path
// assumes mode 0 timing and a 32 ns serial clock owned by this model
`timescale 1ns/1ns
`default_nettype none

module spi_host_model (
    output var logic sck,
    output var logic cs_b,
    output var logic si
);
    // ****************************************************************
    // framing
    // ****************************************************************
    initial begin
        sck = 1'b0;
        cs_b = 1'b1;
        si = 1'b0;
    end

    // clock stands still between frames; the released data line is
    // inverted so a stale bit never passes for a driven one
    task automatic frame(input logic [7:0] q[$]);
        cs_b = 1'b0;
        #16;
        foreach (q[i]) begin
            for (int b = 7; b >= 0; b--) begin
                si = q[i][b];
                #16 sck = 1'b1;
                #16 sck = 1'b0;
            end
        end
        #32 si = ~si;
        cs_b = 1'b1;
        #100;
    endtask
endmodule // spi_host_model

`default_nettype wire

/* verif/testbench.sv */
// self-checking bench for the buffer-write and page-program path
// assumes spi_host_model drives the link and a model of both buffers
`timescale 1ns/1ns
`default_nettype none

module testbench;
    import flash_write_pkg::*;
    localparam int PROG_N = 300;
    localparam int EP_N = 400;
    logic clk, rst_b, page_256, array_fail;
    logic busy, erase_program_error_flag, array_erase;
    logic [10:0] array_page;
    array_wr_t array_wr;
    wire logic sck, cs_b, si;
    logic [27:0] got_q[$];
    int busy_n, ers_n, miscompares, n_tests;
    // -1 marks a buffer byte whose content is unknown after reset
    int bufm[2][264];

    spi_host_model host (.sck(sck), .cs_b(cs_b), .si(si));
    flash_write_path #(.PROG_CYC(PROG_N), .EP_CYC(EP_N)) dut (
        .clk(clk), .rst_b(rst_b), .sck(sck), .cs_b(cs_b), .si(si),
        .page_256(page_256), .array_fail(array_fail), .busy(busy),
        .erase_program_error_flag(erase_program_error_flag),
        .array_erase(array_erase), .array_page(array_page),
        .array_wr(array_wr)
    );

    // ****************************************************************
    // clock and monitor
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // sampled on the falling edge, where the registered outputs have settled
    always @(negedge clk) begin
        if (array_wr.valid === 1'b1) got_q.push_back(array_wr[27:0]);
        if (busy === 1'b1) busy_n++;
        if (array_erase === 1'b1) ers_n++;
    end

    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic chk(input string what, input logic [31:0] got,
                       input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t %s got %0h expected %0h", $time, what,
                     got, exp);
        end
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic wait_busy(input logic lvl, input int lim);
        int i;
        // realign to the falling edge, the frame ends off the clk grid
        @(negedge clk);
        for (i = 0; i < lim && busy !== lvl; i++) @(negedge clk);
        if (busy !== lvl) begin
            miscompares++;
            $display("ERROR %0t busy wait ran out", $time);
            close_out();
        end
    endtask

    task automatic do_reset(input logic narrow);
        @(negedge clk);
        rst_b = 1'b0;
        page_256 = narrow;
        foreach (bufm[s, k]) bufm[s][k] = -1;
        repeat (3) @(negedge clk);
        rst_b = 1'b1;
        repeat (4) @(negedge clk);
        chk("busy after reset", busy, 0);
        chk("error after reset", erase_program_error_flag, 0);
        chk("page after reset", array_page, 0);
    endtask

    // one frame; data bytes go to the buffer model, program jobs are
    // followed to completion and their write stream compared
    task automatic job(input logic [7:0] op, input int pg, input int off,
                       input int nd, input logic fail);
        logic [7:0] q[$];
        logic [23:0] a;
        logic [7:0] d;
        int ln, bs, er;
        ln = page_256 ? 256 : 264;
        bs = op inside {8'h87, 8'h86, 8'h89, 8'h85};
        er = op inside {8'h83, 8'h86, 8'h82, 8'h85};
        // top bit is a don't-care and is set to prove it is ignored
        a = 24'h80_0000 | 24'(page_256 ? (pg << 8) : (pg << 9)) | 24'(off);
        q = {op, a[23:16], a[15:8], a[7:0]};
        for (int i = 0; i < nd; i++) begin
            d = 8'($urandom);
            q.push_back(d);
            bufm[bs][(off + i) % ln] = d;
        end
        got_q.delete();
        busy_n = 0;
        ers_n = 0;
        host.frame(q);
        if (nd == 0 || er != 0) begin
            wait_busy(1'b1, 20);
            if (fail) begin
                array_fail = 1'b1;
                @(negedge clk);
                array_fail = 1'b0;
            end
            wait_busy(1'b0, 1000);
            chk("busy length", busy_n, er ? EP_N : PROG_N);
            chk("erase pulses", ers_n, er);
            chk("page", array_page, pg);
            chk("error flag", erase_program_error_flag, fail);
            chk("bytes written", got_q.size(), ln);
            foreach (got_q[i]) begin
                chk("write page", got_q[i][27:17], pg);
                chk("write offset", got_q[i][16:8], i);
                if (bufm[bs][i] >= 0) begin
                    chk("write data", got_q[i][7:0], bufm[bs][i]);
                end
            end
        end
        $display("test with opcode %0h done", op);
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        rst_b = 1'b0;
        page_256 = 1'b0;
        array_fail = 1'b0;
        void'($urandom(32'h25fb_7a9b));
        do_reset(1'b0);
        job(8'h84, 0, 5, 266, 1'b0);
        job(8'h83, 11'h5a5, 9'h1ff, 0, 1'b0);
        job(8'h87, 0, 263, 3, 1'b0);
        job(8'h86, 11'h02a, 9'h033, 0, 1'b1);
        job(8'h85, 11'h7ff, 0, 264, 1'b0);
        // target page taken as already erased by the host
        job(8'h88, 11'h123, 9'h0aa, 0, 1'b0);
        job(8'h89, 11'h001, 0, 0, 1'b1);
        // an opcode outside this path must start no job
        host.frame({8'h81, 8'h00, 8'h02, 8'h00});
        repeat (20) @(negedge clk);
        chk("busy on unknown opcode", busy, 0);
        $display("test with unknown opcode done");
        do_reset(1'b1);
        job(8'h87, 0, 8'hfe, 4, 1'b0);
        job(8'h86, 11'h400, 8'h5c, 0, 1'b0);
        job(8'h82, 11'h0f0, 3, 256, 1'b1);
        job(8'h88, 11'h3c3, 8'h7e, 0, 1'b0);
        close_out();
    end
endmodule // testbench

`default_nettype wire
